// File: rtl/retire_tag_pkg.sv
// Shared types and constants for the retirement event tagging block.
package retire_tag_pkg;

   // Width of the micro-operation identifier carried through the pipeline.
   localparam int UOP_ID_W = 4;
   // Width of the execution tag value and of a selector event mask.
   localparam int TAG_W = 4;
   // Mask bit positions for the path-qualified counting events.
   localparam int MASK_COMMITTED = 0;
   localparam int MASK_SPECULATIVE = 1;
   // Counter reset value.
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

   // Counting event choices; the first one (code zero) is the null event.
   typedef enum logic [2:0] {
      EV_NULL,
      EV_FRONT_END,
      EV_EXECUTION,
      EV_REPLAY,
      EV_INSTR_RETIRED,
      EV_UOPS_RETIRED,
      EV_EXEC_RAW
   } event_sel_e;

   // Tagging mechanism that raised a tag event.
   typedef enum logic [1:0] {
      MECH_FRONT_END,
      MECH_EXECUTION,
      MECH_REPLAY
   } tag_mech_e;

   // One event selector together with the enable of the counter it feeds.
   typedef struct packed {
      logic enable;
      event_sel_e code;
      logic [TAG_W-1:0] mask;
   } selector_s;

   // Tag state that travels with one micro-operation.
   typedef struct packed {
      logic front_end;
      logic [TAG_W-1:0] exec;
      logic replay;
   } uop_tags_s;

   // Allocation of a micro-operation into the tracked window.
   typedef struct packed {
      logic valid;
      logic [UOP_ID_W-1:0] id;
      logic untaggable;
   } alloc_s;

   // Detection of a taggable event on one micro-operation.
   typedef struct packed {
      logic valid;
      logic [UOP_ID_W-1:0] id;
      tag_mech_e mech;
      logic [TAG_W-1:0] value;
   } tag_evt_s;

   // A micro-operation leaving the retirement stage.
   typedef struct packed {
      logic valid;
      logic [UOP_ID_W-1:0] id;
      logic bogus;
      logic instr_end;
   } retire_s;

endpackage

// File: rtl/uop_tag_table.sv
// Per micro-operation tag storage, set by event detection and read at retirement.
module uop_tag_table #(
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic tag_active,
   input retire_tag_pkg::alloc_s alloc,
   input retire_tag_pkg::tag_evt_s tag_evt,
   input retire_tag_pkg::retire_s retire,
   output retire_tag_pkg::uop_tags_s retire_tags
);

   initial begin
      if (DEPTH < 2 || DEPTH > (1 << retire_tag_pkg::UOP_ID_W)) begin
         $error("uop_tag_table: DEPTH does not fit the identifier width");
      end
   end

   retire_tag_pkg::uop_tags_s tags_reg [DEPTH];
   logic untaggable_reg [DEPTH];

   // An untaggable class or a powered-down tagger never marks the entry.
   wire logic evt_ok = tag_evt.valid && tag_active && !untaggable_reg[tag_evt.id];
   wire logic evt_fe = evt_ok && (tag_evt.mech == retire_tag_pkg::MECH_FRONT_END);
   wire logic evt_ex = evt_ok && (tag_evt.mech == retire_tag_pkg::MECH_EXECUTION);
   wire logic evt_rp = evt_ok && (tag_evt.mech == retire_tag_pkg::MECH_REPLAY);

   // The tags are read in the retirement stage for the retiring entry.
   assign retire_tags = tags_reg[retire.id];

   // Tags only ever OR in, so a repeated event leaves one mark. A new allocation
   // starts a fresh lifetime; retirement discards the tags, bogus or not.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            tags_reg[i] <= '0;
            untaggable_reg[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (alloc.valid && alloc.id == i) begin
               tags_reg[i] <= '0;
               untaggable_reg[i] <= alloc.untaggable;
            end else if (retire.valid && retire.id == i) begin
               tags_reg[i] <= '0;
            end else if (tag_evt.id == i) begin
               tags_reg[i].front_end <= tags_reg[i].front_end | evt_fe;
               tags_reg[i].exec <= tags_reg[i].exec | (evt_ex ? tag_evt.value : '0);
               tags_reg[i].replay <= tags_reg[i].replay | evt_rp;
            end
         end
      end
   end

   // An event aimed at an untaggable entry must leave that entry without tags.
   a_untaggable_stays: assert property (@(posedge sys_clk) disable iff (!reset_n)
      tag_evt.valid && untaggable_reg[tag_evt.id] |=> tags_reg[$past(tag_evt.id)] == '0)
      else $error("untaggable micro-operation was tagged");

endmodule // uop_tag_table

// File: rtl/retire_tag_counter.sv
// Retirement event tagging and counting: tag table plus selector-driven counters.
//
// Operation
// - Retirement counting counts committed work, and discarded speculative work only where the speculative mask bit is set.
// - Each micro-operation is exactly one of speculative or committed.
// - A micro-operation is tagged at most once and counted once at retirement.
// - Both raw event occurrences and tagged micro-operations can be counted.
// - Four mechanisms: front-end, execution, replay tags and untagged counting.
// - A tag from one mechanism is invisible to every other mechanism's counter.
// - Execution tagging counts up to four micro-operation types separately.
// - Replay tagging marks replayed micro-operations and mispredicted branches.
// - Untagged counting counts retired instructions and micro-operations without tags.
// - Precise sampling supports one mechanism at a time; a conflict is flagged.
// - I/O, uncacheable, locked, return and far transfer operations are never tagged.
// - Front-end counting needs the committed or speculative mask bit set.
// - A committed tagged operation adds one when any tag bit chosen by the mask is set.
module retire_tag_counter #(
   parameter int NUM_COUNTERS = 4,
   parameter int COUNT_W = 32,
   parameter int TABLE_DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input retire_tag_pkg::selector_s [NUM_COUNTERS-1:0] selector,
   input wire logic precise_sampling,
   input retire_tag_pkg::alloc_s alloc,
   input retire_tag_pkg::tag_evt_s tag_evt,
   input retire_tag_pkg::retire_s retire,
   output logic [NUM_COUNTERS-1:0][COUNT_W-1:0] count,
   output logic precise_conflict
);

   initial begin
      if (NUM_COUNTERS < 1 || COUNT_W < 2 || COUNT_W > 32) begin
         $error("retire_tag_counter: unsupported counter count or width");
      end
   end

   retire_tag_pkg::uop_tags_s retire_tags;
   logic [NUM_COUNTERS-1:0][COUNT_W-1:0] count_reg;
   logic [NUM_COUNTERS-1:0] hit;
   logic precise_conflict_reg;
   logic precise_conflict_next;

   // Does one selector count on this cycle? Kept in one place for every counter.
   function automatic logic counts_now(input retire_tag_pkg::selector_s sel,
                                       input retire_tag_pkg::retire_s ret,
                                       input retire_tag_pkg::uop_tags_s tags,
                                       input retire_tag_pkg::tag_evt_s evt);
      logic path_ok;
      logic committed;
      path_ok = 1'b0;
      committed = ret.valid && !ret.bogus;
      // A bogus operation only counts where the speculative mask bit asks.
      if (ret.valid) begin
         path_ok = ret.bogus ? sel.mask[retire_tag_pkg::MASK_SPECULATIVE]
                             : sel.mask[retire_tag_pkg::MASK_COMMITTED];
      end
      counts_now = 1'b0;
      if (sel.enable) begin
         unique case (sel.code)
            retire_tag_pkg::EV_NULL: counts_now = 1'b0;
            retire_tag_pkg::EV_FRONT_END: counts_now = path_ok && tags.front_end;
            retire_tag_pkg::EV_EXECUTION: counts_now = committed && |(tags.exec & sel.mask);
            retire_tag_pkg::EV_REPLAY: counts_now = path_ok && tags.replay;
            retire_tag_pkg::EV_INSTR_RETIRED: counts_now = path_ok && ret.instr_end;
            retire_tag_pkg::EV_UOPS_RETIRED: counts_now = path_ok;
            retire_tag_pkg::EV_EXEC_RAW: counts_now = evt.valid
               && evt.mech == retire_tag_pkg::MECH_EXECUTION && |(evt.value & sel.mask);
            default: counts_now = 1'b0;
         endcase
      end
   endfunction

   // Is this selector using a tagging mechanism, and which one?
   function automatic logic [2:0] mech_used(input retire_tag_pkg::selector_s sel);
      mech_used = '0;
      if (sel.enable) begin
         mech_used[0] = sel.code == retire_tag_pkg::EV_FRONT_END;
         mech_used[1] = sel.code == retire_tag_pkg::EV_EXECUTION;
         mech_used[2] = sel.code == retire_tag_pkg::EV_REPLAY;
      end
   endfunction

   // With no counter enabled the taggers sit powered down.
   logic [NUM_COUNTERS-1:0] enables;
   logic [2:0] mechs;
   always_comb begin
      mechs = '0;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         enables[i] = selector[i].enable;
         mechs = mechs | mech_used(selector[i]);
      end
   end
   wire logic tag_active = |enables;

   // Tags are shared under precise sampling, so two mechanisms at once are reported.
   assign precise_conflict_next = precise_sampling && ($countones(mechs) > 1);

   uop_tag_table #(
      .DEPTH(TABLE_DEPTH)
   ) u_tags (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tag_active(tag_active),
      .alloc(alloc),
      .tag_evt(tag_evt),
      .retire(retire),
      .retire_tags(retire_tags)
   );

   // Counter decision per selector; each adds at most one per cycle.
   always_comb begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         hit[i] = counts_now(selector[i], retire, retire_tags, tag_evt);
      end
   end

   // Counters wrap on overflow; overflow handling lives elsewhere.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '{default: retire_tag_pkg::COUNT_RESET[COUNT_W-1:0]};
         precise_conflict_reg <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            count_reg[i] <= count_reg[i] + COUNT_W'(hit[i]);
         end
         precise_conflict_reg <= precise_conflict_next;
      end
   end

   assign count = count_reg;
   assign precise_conflict = precise_conflict_reg;

   // Checks on counter 0; the counters are identical copies of the same logic.
   wire retire_tag_pkg::selector_s sel0 = selector[0];

   // Second and last counters are checked too, so more event codes meet a live antecedent.
   localparam int SEL_B = (NUM_COUNTERS > 1) ? 1 : 0;
   localparam int SEL_C = NUM_COUNTERS - 1;
   wire retire_tag_pkg::selector_s sel_b = selector[SEL_B];
   wire retire_tag_pkg::selector_s sel_c = selector[SEL_C];

   a_raw_counted: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sel_b.enable && sel_b.code == retire_tag_pkg::EV_EXEC_RAW && tag_evt.valid
      && tag_evt.mech == retire_tag_pkg::MECH_EXECUTION && |(tag_evt.value & sel_b.mask)
      |=> count[SEL_B] == $past(count[SEL_B]) + COUNT_W'(1))
      else $error("raw execution event not counted");

   a_fe_path_needed: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && retire.bogus && sel_b.code == retire_tag_pkg::EV_FRONT_END
      && !sel_b.mask[retire_tag_pkg::MASK_SPECULATIVE] |=> $stable(count[SEL_B]))
      else $error("front-end count without its path mask bit");

   a_uops_counted: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && !retire.bogus && sel_c.enable
      && sel_c.code == retire_tag_pkg::EV_UOPS_RETIRED && sel_c.mask[retire_tag_pkg::MASK_COMMITTED]
      |=> count[SEL_C] == $past(count[SEL_C]) + COUNT_W'(1))
      else $error("retired micro-operation not counted");

   a_null_never_counts: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sel0.code == retire_tag_pkg::EV_NULL |=> count[0] == $past(count[0]))
      else $error("null event changed a counter");

   a_disabled_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !sel0.enable [*2] |=> $stable(count[0]))
      else $error("disabled counter moved");

   a_step_at_most_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
      count[0] - $past(count[0]) <= COUNT_W'(1))
      else $error("counter advanced by more than one");

   a_bogus_not_committed: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && retire.bogus && sel0.enable
      && !sel0.mask[retire_tag_pkg::MASK_SPECULATIVE]
      && sel0.code != retire_tag_pkg::EV_EXEC_RAW |=> $stable(count[0]))
      else $error("cancelled work reached a committed count");

   a_instr_counted: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && !retire.bogus && retire.instr_end && sel0.enable
      && sel0.code == retire_tag_pkg::EV_INSTR_RETIRED
      && sel0.mask[retire_tag_pkg::MASK_COMMITTED]
      |=> count[0] == $past(count[0]) + COUNT_W'(1))
      else $error("retired instruction not counted");

   a_exec_tag_counted: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && !retire.bogus && sel0.enable
      && sel0.code == retire_tag_pkg::EV_EXECUTION && |(retire_tags.exec & sel0.mask)
      |=> count[0] == $past(count[0]) + COUNT_W'(1))
      else $error("execution tagged operation not counted");

   a_other_tag_unseen: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && sel0.code == retire_tag_pkg::EV_REPLAY && !retire_tags.replay
      |=> $stable(count[0]))
      else $error("replay counter saw a foreign tag");

   a_replay_counted: assert property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && !retire.bogus && sel0.enable && retire_tags.replay
      && sel0.code == retire_tag_pkg::EV_REPLAY
      && sel0.mask[retire_tag_pkg::MASK_COMMITTED]
      |=> count[0] == $past(count[0]) + COUNT_W'(1))
      else $error("replay tagged operation not counted");

   a_precise_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !precise_sampling |=> !precise_conflict)
      else $error("conflict flagged without precise sampling");

   c_exec_count: cover property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && !retire.bogus && |retire_tags.exec);
   c_bogus_retire: cover property (@(posedge sys_clk) disable iff (!reset_n)
      retire.valid && retire.bogus && retire_tags.front_end);
   c_raw_event: cover property (@(posedge sys_clk) disable iff (!reset_n)
      hit[0] && sel0.code == retire_tag_pkg::EV_EXEC_RAW);
   c_precise_conflict: cover property (@(posedge sys_clk) disable iff (!reset_n)
      precise_conflict);
   c_uops_retired: cover property (@(posedge sys_clk) disable iff (!reset_n)
      hit[SEL_C] && sel_c.code == retire_tag_pkg::EV_UOPS_RETIRED);

endmodule // retire_tag_counter

// File: tb/pipe_model.sv
// Behavioural model of the pipeline that allocates, tags and retires micro-operations.
module pipe_model (
   input wire logic sys_clk,
   output retire_tag_pkg::alloc_s alloc,
   output retire_tag_pkg::tag_evt_s tag_evt,
   output retire_tag_pkg::retire_s retire
);
   timeunit 1ns;
   timeprecision 1ns;

   // The pipeline is idle until the bench hands it work.
   initial begin
      alloc = '0;
      tag_evt = '0;
      retire = '0;
   end

   // One micro-operation: allocate, then the same event one or more times, then retire.
   // Each pulse is changed only at a falling edge so the design samples it settled.
   task automatic run_uop(input logic [3:0] id, input logic untag,
                          input retire_tag_pkg::tag_mech_e mech, input logic [3:0] value,
                          input int reps, input logic bogus, input logic instr_end);
      @(negedge sys_clk);
      alloc <= '{1'b1, id, untag};
      @(negedge sys_clk);
      alloc <= '0;
      // Repeating an event on one operation must not count it twice on a tagged counter; EV_EXEC_RAW counts each repeat.
      repeat (reps) begin
         tag_evt <= '{1'b1, id, mech, value};
         @(negedge sys_clk);
      end
      tag_evt <= '0;
      // An operation leaves as either cancelled or committed, never both.
      retire <= '{1'b1, id, bogus, instr_end};
      @(negedge sys_clk);
      retire <= '0;
   endtask
endmodule // pipe_model

// File: tb/retire_tag_counter_tb_top.sv
// Self-checking bench for the retirement tagging counters with corner and random traffic.
module retire_tag_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk;
   logic reset_n;
   retire_tag_pkg::selector_s [3:0] selector;
   logic precise_sampling;
   retire_tag_pkg::alloc_s alloc;
   retire_tag_pkg::tag_evt_s tag_evt;
   retire_tag_pkg::retire_s retire;
   logic [3:0][31:0] count;
   logic precise_conflict;
   int fails;
   int check_count;
   int exp_cnt [4];
   retire_tag_pkg::selector_s cfg [2][4];

   retire_tag_counter i_retire_tag_counter (.sys_clk(sys_clk), .reset_n(reset_n),
      .selector(selector), .precise_sampling(precise_sampling), .alloc(alloc),
      .tag_evt(tag_evt), .retire(retire), .count(count), .precise_conflict(precise_conflict));

   pipe_model i_pipe_model (.sys_clk(sys_clk), .alloc(alloc), .tag_evt(tag_evt),
      .retire(retire));

   // A 100 ns period clock.
   always #50 sys_clk = ~sys_clk;

   // Compare one value and report at once on a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   // Print the totals and the verdict, then stop.
   task automatic finish_test();
      $display("Totals: %0d mismatches in %0d comparisons", fails, check_count);
      if (fails == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hold reset low for three cycles; counts restart from zero afterwards.
   task automatic do_reset();
      @(negedge sys_clk);
      reset_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
   endtask

   // Increment one selector should see for one retired operation.
   function automatic int incr(retire_tag_pkg::selector_s s, logic un,
                               retire_tag_pkg::tag_mech_e m, logic [3:0] v, int reps,
                               logic bg, logic ie);
      logic path;
      path = bg ? s.mask[retire_tag_pkg::MASK_SPECULATIVE] :
                  s.mask[retire_tag_pkg::MASK_COMMITTED];
      if (!s.enable) return 0;
      case (s.code)
         retire_tag_pkg::EV_FRONT_END: return int'(!un && m == retire_tag_pkg::MECH_FRONT_END && path);
         retire_tag_pkg::EV_EXECUTION: return int'(!un && m == retire_tag_pkg::MECH_EXECUTION && !bg && (v & s.mask) != 0);
         retire_tag_pkg::EV_REPLAY: return int'(!un && m == retire_tag_pkg::MECH_REPLAY && path);
         retire_tag_pkg::EV_INSTR_RETIRED: return int'(ie && path);
         retire_tag_pkg::EV_UOPS_RETIRED: return int'(path);
         retire_tag_pkg::EV_EXEC_RAW: return (m == retire_tag_pkg::MECH_EXECUTION && (v & s.mask) != 0) ? reps : 0;
         default: return 0;
      endcase
   endfunction

   // The whole run needs well under a thousand cycles; this cuts a hang short.
   initial begin
      #(5000 * 100);
      fails++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      finish_test();
   end

   // Two configuration rounds; the first starts with corner cases, and both run random traffic.
   initial begin
      logic un;
      logic bg;
      logic ie;
      logic [3:0] v;
      int reps;
      retire_tag_pkg::tag_mech_e m;
      sys_clk = 1'b0;
      reset_n = 1'b0;
      precise_sampling = 1'b0;
      selector = '0;
      fails = 0;
      check_count = 0;
      // Every counter is enabled with a real event, except the deliberate null one and the disabled last counter of the second round.
      cfg[0] = '{'{1'b1, retire_tag_pkg::EV_EXECUTION, 4'h5},
                 '{1'b1, retire_tag_pkg::EV_FRONT_END, 4'h1},
                 '{1'b1, retire_tag_pkg::EV_REPLAY, 4'h2},
                 '{1'b1, retire_tag_pkg::EV_UOPS_RETIRED, 4'h3}};
      cfg[1] = '{'{1'b1, retire_tag_pkg::EV_INSTR_RETIRED, 4'h1},
                 '{1'b1, retire_tag_pkg::EV_EXEC_RAW, 4'hF},
                 '{1'b1, retire_tag_pkg::EV_NULL, 4'h3},
                 '{1'b0, retire_tag_pkg::EV_EXECUTION, 4'hF}};
      void'($urandom(8));
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 4; k++) begin
            selector[k] = cfg[r][k];
            exp_cnt[k] = 0;
         end
         do_reset();
         precise_sampling = 1'b1;
         repeat (2) @(negedge sys_clk);
         check({31'h0, precise_conflict}, (r == 0) ? 32'h1 : 32'h0, "conflict flag");
         for (int i = 0; i < 40; i++) begin
            un = (r == 0) ? 1'($urandom_range(0, 1)) : 1'b0;
            m = retire_tag_pkg::tag_mech_e'($urandom_range(0, 2));
            v = 4'($urandom_range(1, 15));
            reps = $urandom_range(1, 3);
            bg = 1'($urandom_range(0, 1));
            ie = 1'($urandom_range(0, 1));
            // Untaggable op, triple event, cancelled op and a cancelled front-end tag.
            if (r == 0 && i < 4) begin
               un = (i == 0);
               m = (i == 3) ? retire_tag_pkg::MECH_FRONT_END : retire_tag_pkg::MECH_EXECUTION;
               v = (i == 0) ? 4'hF : 4'h1;
               reps = (i == 1) ? 3 : 2;
               bg = (i >= 2);
               ie = 1'b1;
            end
            for (int k = 0; k < 4; k++) begin
               exp_cnt[k] += incr(cfg[r][k], un, m, v, reps, bg, ie);
            end
            i_pipe_model.run_uop(4'(i), un, m, v, reps, bg, ie);
         end
         repeat (2) @(negedge sys_clk);
         for (int k = 0; k < 4; k++) begin
            check(count[k], 32'(exp_cnt[k]), "counter value");
         end
      end
      // With sampling off the conflict flag must stay clear.
      precise_sampling = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({31'h0, precise_conflict}, 32'h0, "conflict clear");
      finish_test();
   end
endmodule // retire_tag_counter_tb_top
